//--- logic/lcdsd_pkg.sv
// Package for the segment LCD driver: register offsets, field positions, reset values.
// Assumes a single 50 MHz bus clock and word-aligned AHB-Lite register access.
package lcdsd_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_PRESCALE = 8'h00;
	localparam logic [7:0] OFS_SEGEN = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_SLEEP = 8'h14;
	localparam logic [7:0] OFS_STATE = 8'h18;
	localparam logic [7:0] OFS_PIXEL_FIRST = 8'h40;
	localparam logic [7:0] OFS_PIXEL_LAST = 8'h7C;
	// Control register fields
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_SLEEP_SEL_BIT = 6;
	localparam int CTL_INTERNAL_VOLTAGE_GEN_EN_BIT = 4;
	localparam int CTL_CS_LSB = 2;
	localparam int CTL_MUX_LSB = 0;
	localparam int PS_MSB = 3;
	// Reset values: module off, all pins driver function
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_PRESCALE = 8'h00;
	localparam logic [7:0] RST_SEGEN = 8'hFF;
	// Base ticks per frame-clock step before prescale, per timing source
	localparam logic [15:0] BASE_DIV_SYS = 16'h0400;
	localparam logic [15:0] BASE_DIV_TMR = 16'h0100;
	localparam logic [15:0] BASE_DIV_RC = 16'h0200;
	// Sizes: pixel registers, segment lines, commons and segment-enable pin groups
	localparam int NUM_PIXEL_REGS = 16;
	localparam int NUM_SEGS = 32;
	localparam int NUM_COMS = 4;
	localparam int NUM_GROUPS = 8;
endpackage

//--- logic/lcdsd_tick_if.sv
// Interface carrying the frame-clock tick from the prescaler to the driver core.
// Assumes both ends share hclk.
`timescale 1ns/1ps
interface lcdsd_tick_if;
	logic tick;
	logic run;
	modport src(output tick, input run);
	modport dst(input tick, output run);
endinterface

//--- logic/lcdsd_prescaler.sv
// Frame-clock prescaler: divides the selected timing source tick by its base division, then by (prescale+1).
// Assumes the timing source enable pulses are synchronous to hclk.
`timescale 1ns/1ps
module lcdsd_prescaler (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] timing_source_sel,
	input wire logic [3:0] frame_prescale_sel,
	input wire logic tmr_osc_tick,
	input wire logic rc_osc_tick,
	lcdsd_tick_if.src tk
);
	logic [15:0] base_cnt;
	logic [15:0] next_base_cnt;
	logic [3:0] ps_cnt;
	logic [3:0] next_ps_cnt;
	logic tick_q;
	logic next_tick_q;
	logic src_en;
	logic [15:0] base_lim;

	assign tk.tick = tick_q;

	// Pick source pulse and base division; system clock counts every cycle
	always_comb begin
		unique case (timing_source_sel)
			2'b00: begin
				src_en = 1'b1;
				base_lim = lcdsd_pkg::BASE_DIV_SYS;
			end
			2'b01: begin
				src_en = tmr_osc_tick;
				base_lim = lcdsd_pkg::BASE_DIV_TMR;
			end
			default: begin
				src_en = rc_osc_tick;
				base_lim = lcdsd_pkg::BASE_DIV_RC;
			end
		endcase
	end

	// Two-stage division; counters hold at zero while the driver is stopped
	always_comb begin
		next_base_cnt = base_cnt;
		next_ps_cnt = ps_cnt;
		next_tick_q = 1'b0;
		if (!tk.run) begin
			next_base_cnt = 16'h0000;
			next_ps_cnt = 4'h0;
		end else if (src_en) begin
			if (base_cnt >= base_lim - 16'h0001) begin
				next_base_cnt = 16'h0000;
				if (ps_cnt >= frame_prescale_sel) begin
					next_ps_cnt = 4'h0;
					next_tick_q = 1'b1;
				end else begin
					next_ps_cnt = ps_cnt + 4'h1;
				end
			end else begin
				next_base_cnt = base_cnt + 16'h0001;
			end
		end
	end

	// Register stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			base_cnt <= 16'h0000;
			ps_cnt <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			base_cnt <= next_base_cnt;
			ps_cnt <= next_ps_cnt;
			tick_q <= next_tick_q;
		end
	end
endmodule

//--- logic/lcdsd_top.sv
// Segment LCD driver: AHB-Lite registers, frame sequencer, common/segment drive codes.
// Assumes a single-master AHB-Lite bus on hclk and an external analog stage that turns
// the two-bit level codes into ladder voltages.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Reset leaves the module enable clear, so no waveform is driven.
// - Reset sets every segment-enable bit, so the pins come up as LCD drivers.
// - The low four bits of the prescale register set the frame clock division.
// - A set segment-enable bit gives its pin group to the driver, overriding port direction.
// - The control register holds mux/bias, timing source, voltage gen and sleep select.
// - Sixteen pixel registers hold one bit per pixel, shown on the panel waveforms.
// - A write-one-to-clear frame flag reaches the interrupt line only while enabled.
// - Control bit 7 enables the module; clearing it stops frame generation.
// - Writing 0x17 to control gives sleep drive, voltage gen set, timer source, quarter mux, off.
// - Timer source with prescale 0x06 yields a frame rate near 37 Hz.
// - With sleep select set, core sleep stops drive at once at the minimum level.
// - Control bit 4 enables internal voltage generation, else the external ladder is used.
module lcdsd_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic core_sleep,
	input wire logic tmr_osc_tick,
	input wire logic rc_osc_tick,
	input wire logic [31:0] port_direction_bits,
	output logic [63:0] seg_level,
	output logic [7:0] com_level,
	output logic [31:0] pin_is_driver,
	output logic [31:0] pin_oe_n,
	output logic charge_pump_en,
	output logic irq
);
	lcdsd_tick_if tk();

	logic [7:0] frame_prescale_reg;
	logic [7:0] next_frame_prescale_reg;
	logic [7:0] segment_pin_enable_reg;
	logic [7:0] next_segment_pin_enable_reg;
	logic [7:0] lcd_control_reg;
	logic [7:0] next_lcd_control_reg;
	logic frame_irq_flag;
	logic next_frame_irq_flag;
	logic frame_irq_enable;
	logic next_frame_irq_enable;
	logic [7:0] pixel_mem [lcdsd_pkg::NUM_PIXEL_REGS];
	logic [7:0] next_pixel_mem [lcdsd_pkg::NUM_PIXEL_REGS];
	logic wr_pend;
	logic next_wr_pend;
	logic [7:0] wr_addr;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic [2:0] phase;
	logic [2:0] next_phase;
	logic [63:0] next_seg_level;
	logic [7:0] next_com_level;
	logic [31:0] next_pin_is_driver;
	logic [31:0] next_pin_oe_n;
	logic next_pump;
	logic next_irq;
	logic driver_module_enable;
	logic stop_in_sleep_sel;
	logic internal_voltage_gen_en;
	logic [1:0] multiplex_bias_sel;
	logic [1:0] timing_source_sel;
	logic running;
	logic [2:0] last_phase;
	logic frame_end;
	logic rd_take;

	// Control field decode
	assign driver_module_enable = lcd_control_reg[lcdsd_pkg::CTL_ENABLE_BIT];
	assign stop_in_sleep_sel = lcd_control_reg[lcdsd_pkg::CTL_SLEEP_SEL_BIT];
	assign internal_voltage_gen_en = lcd_control_reg[lcdsd_pkg::CTL_INTERNAL_VOLTAGE_GEN_EN_BIT];
	assign timing_source_sel = lcd_control_reg[lcdsd_pkg::CTL_CS_LSB +: 2];
	assign multiplex_bias_sel = lcd_control_reg[lcdsd_pkg::CTL_MUX_LSB +: 2];
	// Sleep with stop select halts immediately, mid-frame if need be
	assign running = driver_module_enable && !(core_sleep && stop_in_sleep_sel);
	assign tk.run = running;
	// Two phases (positive and inverted) per common keep the panel free of DC
	assign last_phase = {multiplex_bias_sel, 1'b1};
	assign frame_end = tk.tick && (phase == last_phase);
	assign rd_take = hsel && hready && htrans[1] && !hwrite;

	lcdsd_prescaler u_presc (
		.hclk(hclk),
		.hresetn(hresetn),
		.timing_source_sel(timing_source_sel),
		.frame_prescale_sel(frame_prescale_reg[lcdsd_pkg::PS_MSB:0]),
		.tmr_osc_tick(tmr_osc_tick),
		.rc_osc_tick(rc_osc_tick),
		.tk(tk)
	);

	// Bus slave and register file; zero wait states, writes land in the data phase
	always_comb begin
		next_wr_pend = hsel && hready && htrans[1] && hwrite;
		next_wr_addr = wr_pend ? wr_addr : haddr[7:0];
		if (next_wr_pend) begin
			next_wr_addr = haddr[7:0];
		end
		next_frame_prescale_reg = frame_prescale_reg;
		next_segment_pin_enable_reg = segment_pin_enable_reg;
		next_lcd_control_reg = lcd_control_reg;
		next_frame_irq_enable = frame_irq_enable;
		next_frame_irq_flag = frame_irq_flag;
		next_pixel_mem = pixel_mem;
		next_hrdata = 32'h0000_0000;
		if (wr_pend) begin
			unique case (wr_addr)
				lcdsd_pkg::OFS_PRESCALE: next_frame_prescale_reg = {4'h0, hwdata[3:0]};
				lcdsd_pkg::OFS_SEGEN: next_segment_pin_enable_reg = hwdata[7:0];
				lcdsd_pkg::OFS_CONTROL: next_lcd_control_reg = hwdata[7:0];
				lcdsd_pkg::OFS_IRQ_STATUS: begin
					if (hwdata[0]) begin
						next_frame_irq_flag = 1'b0;
					end
				end
				lcdsd_pkg::OFS_IRQ_MASK: next_frame_irq_enable = hwdata[0];
				default: begin
					if (wr_addr >= lcdsd_pkg::OFS_PIXEL_FIRST &&
						wr_addr <= lcdsd_pkg::OFS_PIXEL_LAST && wr_addr[1:0] == 2'b00) begin
						next_pixel_mem[wr_addr[5:2]] = hwdata[7:0];
					end
				end
			endcase
		end
		// Frame boundary sets the flag; set wins over a same-cycle clear
		if (frame_end) begin
			next_frame_irq_flag = 1'b1;
		end
		if (rd_take) begin
			unique case (haddr[7:0])
				lcdsd_pkg::OFS_PRESCALE: next_hrdata = {24'h00_0000, frame_prescale_reg};
				lcdsd_pkg::OFS_SEGEN: next_hrdata = {24'h00_0000, segment_pin_enable_reg};
				lcdsd_pkg::OFS_CONTROL: next_hrdata = {24'h00_0000, lcd_control_reg};
				lcdsd_pkg::OFS_IRQ_STATUS: next_hrdata = {31'h0000_0000, frame_irq_flag};
				lcdsd_pkg::OFS_IRQ_MASK: next_hrdata = {31'h0000_0000, frame_irq_enable};
				lcdsd_pkg::OFS_STATE: next_hrdata = {27'h000_0000, running, 1'b0, phase};
				default: begin
					if (haddr[7:0] >= lcdsd_pkg::OFS_PIXEL_FIRST &&
						haddr[7:0] <= lcdsd_pkg::OFS_PIXEL_LAST) begin
						next_hrdata = {24'h00_0000, pixel_mem[haddr[5:2]]};
					end
				end
			endcase
		end
	end

	// Frame phase sequencer; restarts from phase 0 whenever the driver stops
	always_comb begin
		next_phase = phase;
		if (!running) begin
			next_phase = 3'h0;
		end else if (tk.tick) begin
			next_phase = (phase == last_phase) ? 3'h0 : phase + 3'h1;
		end
	end

	// Drive codes: 0 is the minimum level, 3 the top of the ladder
	always_comb begin
		logic [1:0] com_idx;
		logic inv;
		logic on;
		logic [7:0] prow;
		com_idx = phase[2:1];
		inv = phase[0];
		on = 1'b0;
		prow = 8'h00;
		next_seg_level = 64'h0000_0000_0000_0000;
		next_com_level = 8'h00;
		if (running) begin
			for (int c = 0; c < lcdsd_pkg::NUM_COMS; c++) begin
				if (c[1:0] <= multiplex_bias_sel) begin
					if (c[1:0] == com_idx) begin
						next_com_level[2*c +: 2] = inv ? 2'd0 : 2'd3;
					end else begin
						next_com_level[2*c +: 2] = inv ? 2'd2 : 2'd1;
					end
				end
			end
			for (int s = 0; s < lcdsd_pkg::NUM_SEGS; s++) begin
				prow = pixel_mem[{com_idx, s[4:3]}];
				on = prow[s[2:0]];
				if (on) begin
					next_seg_level[2*s +: 2] = inv ? 2'd3 : 2'd0;
				end else begin
					next_seg_level[2*s +: 2] = inv ? 2'd1 : 2'd2;
				end
			end
		end
		for (int p = 0; p < lcdsd_pkg::NUM_SEGS; p++) begin
			next_pin_is_driver[p] = segment_pin_enable_reg[p / 4];
			next_pin_oe_n[p] = segment_pin_enable_reg[p / 4] ? 1'b0 : port_direction_bits[p];
		end
		next_pump = running && internal_voltage_gen_en;
		next_irq = next_frame_irq_flag && frame_irq_enable;
	end

	// Register stage for all state and outputs except hreadyout and hresp
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_prescale_reg <= lcdsd_pkg::RST_PRESCALE;
			segment_pin_enable_reg <= lcdsd_pkg::RST_SEGEN;
			lcd_control_reg <= lcdsd_pkg::RST_CONTROL;
			frame_irq_flag <= 1'b0;
			frame_irq_enable <= 1'b0;
			for (int i = 0; i < lcdsd_pkg::NUM_PIXEL_REGS; i++) begin
				pixel_mem[i] <= 8'h00;
			end
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			phase <= 3'h0;
			seg_level <= 64'h0000_0000_0000_0000;
			com_level <= 8'h00;
			pin_is_driver <= 32'hFFFF_FFFF;
			pin_oe_n <= 32'h0000_0000;
			charge_pump_en <= 1'b0;
			irq <= 1'b0;
		end else begin
			frame_prescale_reg <= next_frame_prescale_reg;
			segment_pin_enable_reg <= next_segment_pin_enable_reg;
			lcd_control_reg <= next_lcd_control_reg;
			frame_irq_flag <= next_frame_irq_flag;
			frame_irq_enable <= next_frame_irq_enable;
			pixel_mem <= next_pixel_mem;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			phase <= next_phase;
			seg_level <= next_seg_level;
			com_level <= next_com_level;
			pin_is_driver <= next_pin_is_driver;
			pin_oe_n <= next_pin_oe_n;
			charge_pump_en <= next_pump;
			irq <= next_irq;
		end
	end

	// Zero wait states and OKAY only
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule

//--- sim/lcdsd_chk_sva.sv
// Checker: bus shadow of control, segment enable and mask, plus drive relations.
// Assumes hreadyout feeds hready and every transfer is a single word.
`timescale 1ns/1ps
module lcdsd_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic core_sleep,
	input wire logic [31:0] port_direction_bits,
	input wire logic [63:0] seg_level,
	input wire logic [7:0] com_level,
	input wire logic [31:0] pin_is_driver,
	input wire logic [31:0] pin_oe_n,
	input wire logic charge_pump_en,
	input wire logic irq
);
	logic wph, rdp, msk;
	logic [7:0] adr, ctl, seg;
	logic [31:0] edrv;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Shadows land at the end of the data phase, as the registers do
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph <= 1'b0;
			rdp <= 1'b0;
			adr <= 8'h00;
			ctl <= 8'h00;
			seg <= 8'hFF;
			msk <= 1'b0;
		end else begin
			wph <= hsel && hready && htrans[1] && hwrite;
			rdp <= hsel && hready && htrans[1] && !hwrite;
			if (hsel && hready && htrans[1]) adr <= haddr[7:0];
			if (wph && adr == lcdsd_pkg::OFS_CONTROL) ctl <= hwdata[7:0];
			if (wph && adr == lcdsd_pkg::OFS_SEGEN) seg <= hwdata[7:0];
			if (wph && adr == lcdsd_pkg::OFS_IRQ_MASK) msk <= hwdata[0];
		end
	end
	// Four pins per segment-enable bit
	always_comb for (int p = 0; p < 32; p++) edrv[p] = seg[p / 4];
	AST_OFF_QUIET: assert property (!ctl[7] |=> seg_level == 0 && com_level == 0)
		else $error("drive seen while disabled");
	AST_PIN_FUNC: assert property (pin_is_driver == $past(edrv))
		else $error("pin function differs from segment enable");
	AST_PIN_OE: assert property (pin_oe_n == $past(port_direction_bits & ~edrv))
		else $error("output enable ignores driver override");
	AST_CTL_READ: assert property (rdp && adr == lcdsd_pkg::OFS_CONTROL |->
		(hrdata[7:0] & 8'hDF) == ($past(ctl) & 8'hDF)) else $error("control read wrong");
	AST_MASK_OFF: assert property (wph && adr == lcdsd_pkg::OFS_IRQ_MASK && !hwdata[0] |->
		##2 !irq) else $error("irq high after mask cleared");
	AST_IRQ_GATE: assert property ($rose(irq) |-> $past(msk))
		else $error("irq rose while masked");
	AST_SLEEP_OFF: assert property (core_sleep && ctl[6] |=> seg_level == 0 && com_level == 0)
		else $error("drive not stopped in sleep");
	AST_PUMP_OFF: assert property (!ctl[4] || !ctl[7] |=> !charge_pump_en)
		else $error("charge pump on without internal generation");
	cover property ($rose(irq));
	cover property (core_sleep && ctl[6] && ctl[7]);
	cover property (rdp && adr == lcdsd_pkg::OFS_CONTROL);
endmodule
bind lcdsd_top lcdsd_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .core_sleep, .port_direction_bits, .seg_level, .com_level,
	.pin_is_driver, .pin_oe_n, .charge_pump_en, .irq);

//--- sim/lcdsd_panel.sv
// Passive glass model: reports whether any line stands above the minimum level.
// Assumes level code 0 is the minimum voltage on every line.
`timescale 1ns/1ps
module lcdsd_panel (
	input wire logic hclk,
	input wire logic [63:0] seg_level,
	input wire logic [7:0] com_level,
	output logic lit
);
	// Registered so the bench reads a settled value
	always_ff @(posedge hclk) lit <= (|seg_level) || (|com_level);
endmodule

//--- sim/tb_top.sv
// Bench: AHB-Lite master tasks, random register traffic, frame timing and sleep cases.
// Assumes zero-wait slave; both timing sources pulse every cycle once out of reset.
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic core_sleep = 1'b0;
	logic tmr_osc_tick = 1'b0;
	logic rc_osc_tick = 1'b0;
	logic [31:0] port_direction_bits = 32'h0000_0000;
	logic [31:0] hrdata, pin_is_driver, pin_oe_n, r, v, seed;
	logic hreadyout, hresp, charge_pump_en, irq, lit;
	logic [63:0] seg_level;
	logic [7:0] com_level;
	logic [7:0] pix [16];
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int t0;
	int tirq;
	always #10 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;
	lcdsd_top u_lcdsd_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .core_sleep, .tmr_osc_tick,
		.rc_osc_tick, .port_direction_bits, .seg_level, .com_level, .pin_is_driver,
		.pin_oe_n, .charge_pump_en, .irq);
	lcdsd_panel u_lcdsd_panel (.hclk, .seg_level, .com_level, .lit);
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected pin ownership: four pins per enable bit
	function logic [31:0] drv(input logic [7:0] g);
		for (int p = 0; p < 32; p++) drv[p] = g[p / 4];
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// One single transfer; read data is taken at the data phase edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0000_0000);
		chk(n, e, r);
	endtask
	// Wait for the frame interrupt, bounded, then clear its flag
	task wirq();
		int i;
		i = 0;
		while (irq !== 1'b1 && i < 40000) begin
			@(posedge hclk);
			i++;
		end
		// Stamp the edge at which the line is seen, so bus traffic does not skew the period
		tirq = cyc;
		if (i >= 40000) chk("irq wait", 1, 0);
		bus(1'b1, lcdsd_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge hclk);
	endtask
	// The first interval may be partial after a reconfiguration, so time the second
	task frames(input logic [3:0] p, input logic [1:0] s, input logic [1:0] m);
		int e;
		e = (s == 2'd1 ? lcdsd_pkg::BASE_DIV_TMR : lcdsd_pkg::BASE_DIV_RC) * (p + 1) * 2 * (m + 1);
		bus(1'b1, lcdsd_pkg::OFS_PRESCALE, {28'h000_0000, p});
		bus(1'b1, lcdsd_pkg::OFS_CONTROL, {24'h00_0000, 4'h9, s, m});
		wirq();
		wirq();
		t0 = tirq;
		wirq();
		chk("frame period", e, tirq - t0);
		$display("test frame done");
	endtask
	task give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (95000) @(posedge hclk);
		error_cnt++;
		$display("watchdog expired");
		give_verdict();
	end
	initial begin
		seed = 32'h1068_38ec;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		tmr_osc_tick <= 1'b1;
		rc_osc_tick <= 1'b1;
		rc(lcdsd_pkg::OFS_CONTROL, 32'h0000_0000, "control");
		rc(lcdsd_pkg::OFS_SEGEN, 32'h0000_00FF, "segment enable");
		rc(8'h30, 32'h0000_0000, "unmapped");
		chk("hresp", 0, 32'(hresp));
		chk("pin_is_driver", 32'hFFFF_FFFF, pin_is_driver);
		chk("lit", 0, 32'(lit));
		$display("test reset done");
		// Random pin split against random port direction; unmapped write dropped
		v = rnd();
		port_direction_bits <= rnd();
		bus(1'b1, lcdsd_pkg::OFS_SEGEN, {24'h00_0000, v[7:0]});
		bus(1'b1, 8'h30, v);
		rc(8'h30, 32'h0000_0000, "unmapped");
		chk("pin_is_driver", drv(v[7:0]), pin_is_driver);
		chk("pin_oe_n", port_direction_bits & ~drv(v[7:0]), pin_oe_n);
		bus(1'b1, lcdsd_pkg::OFS_CONTROL, 32'h0000_0017);
		rc(lcdsd_pkg::OFS_CONTROL, 32'h0000_0017, "control");
		chk("lit", 0, 32'(lit));
		chk("charge_pump_en", 0, 32'(charge_pump_en));
		for (int i = 0; i < 16; i++) begin
			pix[i] = rnd();
			bus(1'b1, lcdsd_pkg::OFS_PIXEL_FIRST + 8'(i * 4), {24'h00_0000, pix[i]});
		end
		for (int i = 0; i < 16; i++) rc(lcdsd_pkg::OFS_PIXEL_FIRST + 8'(i * 4), pix[i], "pixel");
		$display("test registers done");
		// Documented bring-up order, enable last
		bus(1'b1, lcdsd_pkg::OFS_SEGEN, 32'h0000_00FF);
		bus(1'b1, lcdsd_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		bus(1'b1, lcdsd_pkg::OFS_IRQ_MASK, 32'h0000_0001);
		frames(4'h6, 2'd1, 2'd3);
		chk("charge_pump_en", 1, 32'(charge_pump_en));
		chk("lit", 1, 32'(lit));
		bus(1'b1, lcdsd_pkg::OFS_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge hclk);
		chk("irq", 0, 32'(irq));
		// Stop-in-sleep set, then clear so display keeps running
		bus(1'b1, lcdsd_pkg::OFS_CONTROL, 32'h0000_00D7);
		core_sleep <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("lit", 0, 32'(lit));
		core_sleep <= 1'b0;
		bus(1'b1, lcdsd_pkg::OFS_CONTROL, 32'h0000_0097);
		core_sleep <= 1'b1;
		repeat (50) @(posedge hclk);
		chk("lit", 1, 32'(lit));
		core_sleep <= 1'b0;
		bus(1'b1, lcdsd_pkg::OFS_CONTROL, 32'h0000_0007);
		repeat (3) @(posedge hclk);
		chk("lit", 0, 32'(lit));
		chk("charge_pump_en", 0, 32'(charge_pump_en));
		$display("test sleep done");
		v = rnd();
		bus(1'b1, lcdsd_pkg::OFS_IRQ_MASK, 32'h0000_0001);
		frames({3'h0, v[0]}, v[1] ? 2'd2 : 2'd1, v[3:2]);
		give_verdict();
	end
endmodule
